// *** rtl/lsu_pkg.sv ***
// package: shared constants and types of the load/store unit
package lsu_pkg;
  localparam int ADDR_W       = 44;
  localparam int DATA_W       = 64;
  localparam int IO_BIT       = 43;
  localparam int BLK_LSB      = 6;
  localparam int BLK_W        = ADDR_W - BLK_LSB;
  localparam int HALF_BIT     = 5;
  localparam int SLOT_LSB     = 2;
  localparam int SLOT_W       = 4;
  localparam int SLOTS        = 16;
  localparam int SLOT_BITS    = 32;
  localparam int BLK_BITS     = 512;
  localparam int IDX_LO       = 3;
  localparam int IDX_HI       = 14;
  localparam int IDLE_CYCLES  = 1024;
  localparam int WR_PER_CYCLE = 2;
  localparam int IO_WRITE_BUFFER_ENTRIES = 4;
  localparam int SQ_ENTRIES   = 8;
  localparam int LQ_ENTRIES   = 8;
  localparam int MAF_ENTRIES  = 8;

  typedef enum logic [1:0] {
    SZ_BW   = 2'h0,
    SZ_LONG = 2'h1,
    SZ_QUAD = 2'h2
  } size_type;

  typedef enum logic [2:0] {
    MT_LOAD    = 3'h0,
    MT_STORE   = 3'h1,
    MT_STC     = 3'h2,
    MT_HINT    = 3'h3,
    MT_EVICT   = 3'h4,
    MT_ISTREAM = 3'h5,
    MT_DIRTY   = 3'h6
  } miss_kind_type;

  typedef struct packed {
    logic                valid;
    miss_kind_type       kind;
    size_type            size;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } mem_req_type;

  typedef struct packed {
    logic                valid;
    miss_kind_type       kind;
    logic [BLK_W-1:0]    blk;
  } miss_type;

  typedef struct packed {
    logic                valid;
    size_type            size;
    logic [BLK_W-1:0]    blk;
    logic [SLOTS-1:0]    mask;
  } io_group_type;

  typedef struct packed {
    logic                valid;
    size_type            size;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } cache_wr_type;

  typedef struct packed {
    logic                hit;
    logic [DATA_W-1:0]   data;
  } fwd_type;

  typedef struct packed {
    logic                valid;
    logic [BLK_W-1:0]    blk;
    logic [SLOTS-1:0]    mask;
    logic [BLK_BITS-1:0] data;
  } sys_wr_type;

  function automatic logic [SLOTS-1:0] slot_mask(input size_type sz,
                                                 input logic [SLOT_W-1:0] off);
    slot_mask = (sz == SZ_QUAD) ? (16'h0003 << off) : (16'h0001 << off);
  endfunction
endpackage

// *** rtl/io_merge.sv ***
// module: i/o merge register with idle timer
`timescale 1ns/1ps
module io_merge #(
  parameter int IDLE = lsu_pkg::IDLE_CYCLES
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       cfg32_i,
  input  wire logic                       in_valid_i,
  input  lsu_pkg::size_type               in_size_i,
  input  wire logic [lsu_pkg::ADDR_W-1:0] in_addr_i,
  input  wire logic                       act_i,
  input  wire logic                       close_i,
  output logic                            can_o,
  output logic                            open_o,
  output lsu_pkg::io_group_type           flush_o
);
  import lsu_pkg::*;
  localparam int CW = $clog2(IDLE);

  logic             open_q;
  size_type         size_q;
  logic [BLK_W-1:0] blk_q;
  logic             half_q;
  logic [SLOT_W-1:0] last_q;
  logic [SLOTS-1:0] mask_q;
  logic [CW-1:0]    cnt_q;

  wire logic [BLK_W-1:0]  in_blk = in_addr_i[ADDR_W-1:BLK_LSB];
  wire logic [SLOT_W-1:0] in_off = in_addr_i[BLK_LSB-1:SLOT_LSB];
  wire logic half = (size_q == SZ_LONG) || cfg32_i;
  wire logic idle_hit = open_q && (cnt_q == CW'(IDLE - 1));
  wire logic shut = close_i || idle_hit;
  wire logic same_sz = (in_size_i == size_q) && (size_q != SZ_BW);
  wire logic in_blk_ok = (in_blk == blk_q) &&
                         (!half || in_addr_i[HALF_BIT] == half_q) &&
                         (in_off > last_q);
  assign can_o = open_q && !shut && same_sz && in_blk_ok;
  wire logic start = in_valid_i && !can_o;
  wire logic merge = in_valid_i && can_o;
  wire logic closing = open_q && (shut || start);
  assign open_o = open_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      open_q  <= 1'b0;
      flush_o <= '0;
      cnt_q   <= '0;
    end else begin
      open_q  <= start || (open_q && !shut);
      flush_o <= closing ? {1'b1, size_q, blk_q, mask_q} : '0;
      cnt_q   <= (act_i || !open_q) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      size_q <= SZ_BW;
      blk_q  <= '0;
      half_q <= 1'b0;
      last_q <= '0;
      mask_q <= '0;
    end else if (start) begin
      size_q <= in_size_i;
      blk_q  <= in_blk;
      half_q <= in_addr_i[HALF_BIT];
      last_q <= in_off;
      mask_q <= slot_mask(in_size_i, in_off);
    end else if (merge) begin
      last_q <= in_off;
      mask_q <= mask_q | slot_mask(in_size_i, in_off);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_size_split;
    in_valid_i && open_q && in_size_i != size_q
      |=> open_q && mask_q == slot_mask($past(in_size_i), $past(in_off));
  endproperty
  a_size_split: assert property (p_size_split) else $error("size mix merged");

  property p_descend_split;
    in_valid_i && open_q && in_off <= last_q
      |=> last_q == $past(in_off) && $countones(mask_q) <= 2;
  endproperty
  a_descend_split: assert property (p_descend_split) else $error("descend merged");

  property p_long_half;
    flush_o.valid && (flush_o.size == SZ_LONG || (cfg32_i &&
      flush_o.size == SZ_QUAD)) |-> flush_o.mask[15:8] == '0 ||
      flush_o.mask[7:0] == '0;
  endproperty
  a_long_half: assert property (p_long_half) else $error("half block crossed");

  property p_idle_close;
    idle_hit && !in_valid_i |=> !open_q && flush_o.valid;
  endproperty
  a_idle_close: assert property (p_idle_close) else $error("idle no close");

  property p_bar_close;
    close_i && open_q && !in_valid_i |=> !open_q ##0 flush_o.valid;
  endproperty
  a_bar_close: assert property (p_bar_close) else $error("barrier no close");

  c_merge3: cover property (merge ##1 merge ##1 merge);
  c_idle:   cover property (idle_hit);
endmodule // io_merge

// *** rtl/lsu_core.sv ***
// module: load/store queues, i/o merging, miss file merging
`timescale 1ns/1ps
// Contract
// - i/o loads stay in the load queue until retired
// - retired i/o loads replay in order, one per cycle
// - load merge only long with long, quad with quad
// - merged loads ascend, no overlap, within one aligned block
// - config bit limits quad merging to 32-byte blocks
// - barriers or 1024 idle cycles close merge; i/o load issue closes store merge only (load merge idle count resets on i/o store replay only)
// - merged i/o reads leave in delivery order
// - store: enqueue; miss to miss file, clean hit makes dirty
// - entry writable once retired and dirty unshared; two per cycle
// - writable data enters cache in order, two per cycle
// - probe may not evict block with writable entries pending
// - loads match store index bits and take queued data
// - retired i/o stores replay to write buffer, one per cycle
// - queued i/o stores never forward data
// - store merge only long with long, quad with quad
// - merged stores ascend, no overlap, within one aligned block
// - write buffer entries leave in delivery order
// - miss file merges 64-byte blocks, like kinds, load onto store
// - memory: same address and store-store order kept
// - i/o: load-load, store-store, same address order kept
// - write buffer holds four 64-byte entries
module lsu_core #(
  parameter int SQ_D  = lsu_pkg::SQ_ENTRIES,
  parameter int LQ_D  = lsu_pkg::LQ_ENTRIES,
  parameter int MAF_D = lsu_pkg::MAF_ENTRIES,
  parameter int WB_D  = lsu_pkg::IO_WRITE_BUFFER_ENTRIES,
  parameter int IDLE  = lsu_pkg::IDLE_CYCLES
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       one_shot_cfg_32byte_i,
  input  lsu_pkg::mem_req_type            req_i,
  output logic                            req_ready_o,
  input  wire logic                       cache_hit_i,
  input  wire logic                       cache_dirty_i,
  input  wire logic                       retire_ld_i,
  input  wire logic                       retire_st_i,
  input  wire logic                       full_barrier_i,
  input  wire logic                       write_barrier_i,
  input  wire logic                       owned_valid_i,
  input  wire logic [lsu_pkg::BLK_W-1:0]  owned_blk_i,
  input  wire logic [lsu_pkg::BLK_W-1:0]  probe_blk_i,
  output logic                            probe_stall_o,
  output lsu_pkg::fwd_type                fwd_o,
  output lsu_pkg::cache_wr_type [1:0]     cache_wr_o,
  output lsu_pkg::miss_type               miss_o,
  input  wire logic                       maf_done_i,
  output lsu_pkg::io_group_type           io_rd_o,
  output lsu_pkg::sys_wr_type             sys_wr_o,
  input  wire logic                       sys_wr_ready_i
);
  import lsu_pkg::*;
  localparam int SW = $clog2(SQ_D);
  localparam int LW = $clog2(LQ_D);
  localparam int MW = $clog2(MAF_D);
  localparam int WW = $clog2(WB_D);

  logic                cfg_done_q;
  logic                cfg32_q;
  logic [SW:0]         sq_head_q, sq_wp_q, sq_rp_q, sq_tail_q;
  logic [ADDR_W-1:0]   sq_addr_q [SQ_D];
  logic [DATA_W-1:0]   sq_data_q [SQ_D];
  size_type            sq_size_q [SQ_D];
  logic [SQ_D-1:0]     sq_io_q, sq_own_q;
  logic [LW:0]         lq_head_q, lq_rp_q, lq_tail_q;
  logic [ADDR_W-1:0]   lq_addr_q [LQ_D];
  size_type            lq_size_q [LQ_D];
  logic [MW:0]         maf_head_q, maf_tail_q;
  miss_kind_type       maf_kind_q [MAF_D];
  logic [BLK_W-1:0]    maf_blk_q [MAF_D];
  logic [WW:0]         wb_head_q, wb_tail_q;
  logic [BLK_BITS-1:0] wb_data_q [WB_D];
  logic [BLK_W-1:0]    wb_blk_q [WB_D];
  logic [SLOTS-1:0]    wb_mask_q [WB_D];
  logic                st_can, st_open;
  logic                fwd_hit, probe_hit, maf_hit;
  logic [SW-1:0]       fwd_sel;

  // request decode
  wire logic is_io = req_i.addr[IO_BIT];
  wire logic is_ld = req_i.kind == MT_LOAD;
  wire logic is_st = req_i.kind == MT_STORE || req_i.kind == MT_STC;
  wire logic [BLK_W-1:0] req_blk = req_i.addr[ADDR_W-1:BLK_LSB];
  wire logic sq_full = (sq_tail_q - sq_head_q) == (SW+1)'(SQ_D);
  wire logic lq_full = (lq_tail_q - lq_head_q) == (LW+1)'(LQ_D);
  wire logic [MW:0] maf_cnt = maf_tail_q - maf_head_q;
  wire logic maf_full = maf_cnt == (MW+1)'(MAF_D);
  assign req_ready_o = !sq_full && !lq_full && !maf_full;
  wire logic acc = req_i.valid && req_ready_o;
  wire logic sq_push = acc && is_st;
  wire logic lq_push = acc && is_ld && is_io;
  wire logic io_ld_issue = lq_push;

  wire logic st_dirty = is_st && cache_hit_i && !cache_dirty_i;
  wire logic need_miss = (is_ld || is_st) ? (!cache_hit_i || st_dirty) : 1'b1;
  wire logic miss_req = acc && !is_io && need_miss;
  wire miss_kind_type miss_kind = st_dirty ? MT_DIRTY : req_i.kind;

  // store queue pointers and writable walk
  wire logic [SW-1:0] st_t = sq_tail_q[SW-1:0];
  wire logic [SW-1:0] w0 = sq_wp_q[SW-1:0];
  wire logic [SW-1:0] w1 = w0 + 1'b1;
  wire logic [SW-1:0] h0 = sq_head_q[SW-1:0];
  wire logic [SW-1:0] h1 = h0 + 1'b1;
  wire logic ret0 = sq_wp_q != sq_rp_q;
  wire logic ret1 = (sq_rp_q - sq_wp_q) > (SW+1)'(1);
  wire logic wb_full = (wb_tail_q - wb_head_q) == (WW+1)'(WB_D);
  wire logic io_go = ret0 && sq_io_q[w0] && (st_can || !wb_full);
  wire logic wr0 = ret0 && !sq_io_q[w0] && sq_own_q[w0];
  wire logic wr1 = wr0 && ret1 && !sq_io_q[w1] && sq_own_q[w1];
  wire logic [1:0] wp_n = {1'b0, io_go || wr0} + {1'b0, wr1};
  wire logic dr0 = sq_head_q != sq_wp_q;
  wire logic dr1 = (sq_wp_q - sq_head_q) > (SW+1)'(1);
  wire logic [1:0] dr_n = {1'b0, dr0} + {1'b0, dr1};
  wire logic sq_ret = retire_st_i && (sq_rp_q != sq_tail_q);
  wire logic own_push = (cache_hit_i && cache_dirty_i) ||
                        (owned_valid_i && owned_blk_i == req_blk);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg_done_q <= 1'b0;
      cfg32_q    <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      cfg32_q    <= one_shot_cfg_32byte_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sq_head_q <= '0;
      sq_wp_q   <= '0;
      sq_rp_q   <= '0;
      sq_tail_q <= '0;
    end else begin
      sq_head_q <= sq_head_q + (SW+1)'(dr_n);
      sq_wp_q   <= sq_wp_q + (SW+1)'(wp_n);
      sq_rp_q   <= sq_rp_q + (SW+1)'(sq_ret);
      sq_tail_q <= sq_tail_q + (SW+1)'(sq_push);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sq_push) begin
      sq_addr_q[st_t] <= req_i.addr;
      sq_data_q[st_t] <= req_i.data;
      sq_size_q[st_t] <= req_i.size;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sq_io_q  <= '0;
      sq_own_q <= '0;
    end else begin
      for (int i = 0; i < SQ_D; i++) begin
        if (owned_valid_i &&
            sq_addr_q[i][ADDR_W-1:BLK_LSB] == owned_blk_i) begin
          sq_own_q[i] <= 1'b1;
        end
      end
      if (sq_push) begin
        sq_io_q[st_t]  <= is_io;
        sq_own_q[st_t] <= own_push;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cache_wr_o <= '0;
    end else begin
      cache_wr_o[0] <= {dr0 && !sq_io_q[h0], sq_size_q[h0],
                        sq_addr_q[h0], sq_data_q[h0]};
      cache_wr_o[1] <= {dr1 && !sq_io_q[h1], sq_size_q[h1],
                        sq_addr_q[h1], sq_data_q[h1]};
    end
  end

  always_comb begin
    fwd_hit = 1'b0;
    fwd_sel = '0;
    for (int i = 0; i < SQ_D; i++) begin
      if ((SW+1)'(i) < (sq_tail_q - sq_head_q) &&
          !sq_io_q[h0 + SW'(i)] &&
          sq_addr_q[h0 + SW'(i)][IDX_HI:IDX_LO] ==
          req_i.addr[IDX_HI:IDX_LO]) begin
        fwd_hit = 1'b1;
        fwd_sel = h0 + SW'(i);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fwd_o <= '0;
    end else begin
      fwd_o.hit  <= acc && is_ld && !is_io && fwd_hit;
      fwd_o.data <= sq_data_q[fwd_sel];
    end
  end

  always_comb begin
    probe_hit = 1'b0;
    for (int i = 0; i < SQ_D; i++) begin
      if ((SW+1)'(i) < (sq_wp_q - sq_head_q) &&
          !sq_io_q[h0 + SW'(i)] &&
          sq_addr_q[h0 + SW'(i)][ADDR_W-1:BLK_LSB] == probe_blk_i) begin
        probe_hit = 1'b1;
      end
    end
  end
  assign probe_stall_o = probe_hit;

  always_comb begin
    maf_hit = 1'b0;
    for (int i = 0; i < MAF_D; i++) begin
      if ((MW+1)'(i) < maf_cnt &&
          maf_blk_q[maf_head_q[MW-1:0] + MW'(i)] == req_blk &&
          (maf_kind_q[maf_head_q[MW-1:0] + MW'(i)] == miss_kind ||
           (maf_kind_q[maf_head_q[MW-1:0] + MW'(i)] == MT_STORE &&
            miss_kind == MT_LOAD))) begin
        maf_hit = 1'b1;
      end
    end
  end
  wire logic maf_alloc = miss_req && !maf_hit;
  wire logic [MW-1:0] maf_t = maf_tail_q[MW-1:0];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      maf_head_q <= '0;
      maf_tail_q <= '0;
      miss_o     <= '0;
    end else begin
      maf_head_q <= maf_head_q + (MW+1)'(maf_done_i && maf_cnt != '0);
      maf_tail_q <= maf_tail_q + (MW+1)'(maf_alloc);
      miss_o     <= {maf_alloc, miss_kind, req_blk};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (maf_alloc) begin
      maf_kind_q[maf_t] <= miss_kind;
      maf_blk_q[maf_t]  <= req_blk;
    end
  end

  // in-order replay after older i/o stores
  wire logic lq_go = (lq_head_q != lq_rp_q) && !(ret0 && sq_io_q[w0]) &&
                     (wb_head_q == wb_tail_q);
  wire logic [LW-1:0] lh = lq_head_q[LW-1:0];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      lq_head_q <= '0;
      lq_rp_q   <= '0;
      lq_tail_q <= '0;
    end else begin
      lq_head_q <= lq_head_q + (LW+1)'(lq_go);
      lq_rp_q   <= lq_rp_q + (LW+1)'(retire_ld_i && lq_rp_q != lq_tail_q);
      lq_tail_q <= lq_tail_q + (LW+1)'(lq_push);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (lq_push) begin
      lq_addr_q[lq_tail_q[LW-1:0]] <= req_i.addr;
      lq_size_q[lq_tail_q[LW-1:0]] <= req_i.size;
    end
  end

  io_merge #(.IDLE(IDLE)) u_ld_merge (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .cfg32_i    (cfg32_q),
    .in_valid_i (lq_go),
    .in_size_i  (lq_size_q[lh]),
    .in_addr_i  (lq_addr_q[lh]),
    .act_i      (io_go),
    .close_i    (full_barrier_i || write_barrier_i),
    .can_o      (),
    .open_o     (),
    .flush_o    (io_rd_o)
  );

  io_merge #(.IDLE(IDLE)) u_st_merge (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .cfg32_i    (cfg32_q),
    .in_valid_i (io_go),
    .in_size_i  (sq_size_q[w0]),
    .in_addr_i  (sq_addr_q[w0]),
    .act_i      (io_go),
    .close_i    (full_barrier_i || write_barrier_i || io_ld_issue),
    .can_o      (st_can),
    .open_o     (st_open),
    .flush_o    ()
  );

  wire logic st_new = io_go && !st_can;
  wire logic [WW-1:0] wb_cur = st_new ? wb_tail_q[WW-1:0] :
                                        wb_tail_q[WW-1:0] - 1'b1;
  wire logic [SLOT_W-1:0] st_off = sq_addr_q[w0][BLK_LSB-1:SLOT_LSB];
  wire logic [SLOTS-1:0] st_mask = slot_mask(sq_size_q[w0], st_off);
  wire logic [WW-1:0] wh = wb_head_q[WW-1:0];
  wire logic wb_last = (wb_tail_q - wb_head_q) == (WW+1)'(1);
  wire logic wb_send = (wb_head_q != wb_tail_q) && !(wb_last && st_open);
  assign sys_wr_o = {wb_send, wb_blk_q[wh], wb_mask_q[wh], wb_data_q[wh]};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wb_head_q <= '0;
      wb_tail_q <= '0;
    end else begin
      wb_head_q <= wb_head_q + (WW+1)'(wb_send && sys_wr_ready_i);
      wb_tail_q <= wb_tail_q + (WW+1)'(st_new);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (io_go) begin
      if (st_new) begin
        wb_blk_q[wb_cur]  <= sq_addr_q[w0][ADDR_W-1:BLK_LSB];
        wb_mask_q[wb_cur] <= st_mask;
        wb_data_q[wb_cur] <= '0;
      end else begin
        wb_mask_q[wb_cur] <= wb_mask_q[wb_cur] | st_mask;
      end
      if (sq_size_q[w0] == SZ_QUAD) begin
        wb_data_q[wb_cur][st_off*SLOT_BITS +: DATA_W] <= sq_data_q[w0];
      end else begin
        wb_data_q[wb_cur][st_off*SLOT_BITS +: SLOT_BITS] <=
          sq_data_q[w0][SLOT_BITS-1:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_ld_retired;
    lq_head_q != $past(lq_head_q) |-> $past(lq_head_q != lq_rp_q);
  endproperty
  a_ld_retired: assert property (p_ld_retired) else $error("early i/o load");

  property p_ld_rate;
    1 |=> (lq_head_q - $past(lq_head_q)) <= (LW+1)'(1);
  endproperty
  a_ld_rate: assert property (p_ld_rate) else $error("load replay rate");

  property p_wp_rate;
    1 |=> (sq_wp_q - $past(sq_wp_q)) <= (SW+1)'(WR_PER_CYCLE) &&
          (sq_wp_q - sq_head_q) <= (sq_rp_q - sq_head_q);
  endproperty
  a_wp_rate: assert property (p_wp_rate) else $error("writable walk");

  property p_drain;
    1 |=> (sq_head_q - $past(sq_head_q)) <= (SW+1)'(WR_PER_CYCLE) &&
          (sq_wp_q - sq_head_q) <= (sq_tail_q - sq_head_q);
  endproperty
  a_drain: assert property (p_drain) else $error("drain passed writable");

  property p_lock;
    probe_stall_o |-> sq_head_q != sq_wp_q ##1 cache_wr_o[0].valid ||
                      cache_wr_o[1].valid || $past(sq_io_q[h0]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock without drain");

  property p_io_st_rate;
    io_go |=> (sq_wp_q - $past(sq_wp_q)) == (SW+1)'(1);
  endproperty
  a_io_st_rate: assert property (p_io_st_rate) else $error("i/o store rate");

  property p_no_io_fwd;
    fwd_o.hit |-> $past(!is_io) && !$past(sq_io_q[fwd_sel]);
  endproperty
  a_no_io_fwd: assert property (p_no_io_fwd) else $error("i/o forwarded");

  property p_wb_cap;
    (wb_tail_q - wb_head_q) <= (WW+1)'(WB_D);
  endproperty
  a_wb_cap: assert property (p_wb_cap) else $error("write buffer overrun");

  c_fwd:   cover property (fwd_o.hit);
  c_probe: cover property (probe_stall_o ##1 !probe_stall_o);
  c_send:  cover property (wb_send && sys_wr_ready_i ##1 io_rd_o.valid);
endmodule // lsu_core

// *** sim/sys_model.sv ***
// far-side model: system port and miss file release of the controller
`timescale 1ns/1ps
module sys_model (
  input  wire logic           ref_clk_i,
  input  wire logic           srst_i,
  input  lsu_pkg::miss_type   miss_i,
  input  lsu_pkg::sys_wr_type sys_wr_i,
  output logic                maf_done_o,
  output logic                sys_wr_ready_o
);
  import lsu_pkg::*;
  logic [2:0] pace_q;
  logic [3:0] open_q;
  logic       free_now;

  assign free_now = (pace_q == 3'h7) && (open_q != 4'h0);
  assign sys_wr_ready_o = pace_q[1] && sys_wr_i.valid;
  assign maf_done_o = free_now;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pace_q <= 3'h0;
      open_q <= 4'h0;
    end else begin
      pace_q <= pace_q + 3'h1;
      open_q <= open_q + {3'h0, miss_i.valid} - {3'h0, free_now};
    end
  end
endmodule // sys_model

// *** sim/testbench.sv ***
// testbench: directed scenarios for the load/store unit
`timescale 1ns/1ps
module testbench;
  import lsu_pkg::*;
  localparam logic [43:0] IOA = 44'h800_0000_0040;
  localparam logic [43:0] IOB = 44'h800_0000_0080;
  logic ref_clk_i, srst_i, cache_hit, cache_dirty, own_v, req_ready;
  logic stall, maf_done, sys_rdy, cfg32;
  logic [3:0] pul;
  logic [BLK_W-1:0] own_blk;
  mem_req_type req;
  fwd_type fwd, got_fwd;
  miss_type miss, got_miss;
  cache_wr_type [1:0] cwr;
  io_group_type io_rd;
  sys_wr_type sys_wr;
  int miscompares = 0, num_checks = 0, cycles = 0;

  lsu_core #(.IDLE(16)) lsu_core_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .one_shot_cfg_32byte_i(cfg32), .req_i(req), .req_ready_o(req_ready),
    .cache_hit_i(cache_hit), .cache_dirty_i(cache_dirty),
    .retire_ld_i(pul[0]), .retire_st_i(pul[1]), .full_barrier_i(pul[2]),
    .write_barrier_i(pul[3]), .owned_valid_i(own_v), .owned_blk_i(own_blk),
    .probe_blk_i(own_blk), .probe_stall_o(stall), .fwd_o(fwd),
    .cache_wr_o(cwr), .miss_o(miss), .maf_done_i(maf_done),
    .io_rd_o(io_rd), .sys_wr_o(sys_wr), .sys_wr_ready_i(sys_rdy));
  sys_model sys_model_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .miss_i(miss), .sys_wr_i(sys_wr), .maf_done_o(maf_done),
    .sys_wr_ready_o(sys_rdy));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic issue(input miss_kind_type k, input size_type s,
                       input logic [43:0] a, input logic h, input logic d);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req = '{1'b1, k, s, a, {20'h0, a}};
    cache_hit = h;
    cache_dirty = d;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    #1;
    got_miss = miss;
    got_fwd = fwd;
    @(negedge ref_clk_i);
    req.valid = 1'b0;
  endtask

  task automatic pulse(input logic [3:0] p);
    @(negedge ref_clk_i);
    pul = p;
    @(negedge ref_clk_i);
    pul = 4'h0;
  endtask

  task automatic wait_wr(input logic [15:0] m, input logic [43:0] a);
    int n;
    n = 0;
    while (!(sys_wr.valid === 1'b1 && sys_rdy === 1'b1) && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(sys_wr.valid, 1'b1);
    check(sys_wr.mask, m);
    check(sys_wr.blk, a[43:6]);
    @(negedge ref_clk_i);
  endtask

  task automatic t_mem_store;
    int n;
    n = 0;
    issue(MT_STORE, SZ_QUAD, 44'h100, 1'b1, 1'b0);
    check(got_miss.valid, 1'b1);
    check(got_miss.kind, MT_DIRTY);
    issue(MT_LOAD, SZ_QUAD, 44'h100, 1'b0, 1'b0);
    check(got_fwd.hit, 1'b1);
    check(got_fwd.data, 64'h100);
    pulse(4'h2);
    repeat (4) @(negedge ref_clk_i);
    check(cwr[0].valid, 1'b0);
    check(stall, 1'b0);
    own_v = 1'b1;
    @(negedge ref_clk_i);
    own_v = 1'b0;
    @(posedge ref_clk_i);
    #1;
    check(stall, 1'b1);
    while (cwr[0].valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(cwr[0].addr, 44'h100);
    check(cwr[0].data, 64'h100);
    check(cwr[1].valid, 1'b0);
  endtask

  task automatic t_io_store;
    issue(MT_STORE, SZ_LONG, IOA, 1'b0, 1'b0);
    issue(MT_STORE, SZ_LONG, IOA + 44'h8, 1'b0, 1'b0);
    issue(MT_STORE, SZ_QUAD, IOA + 44'h10, 1'b0, 1'b0);
    issue(MT_LOAD, SZ_QUAD, 44'h40, 1'b0, 1'b0);
    check(got_fwd.hit, 1'b0);
    check(got_miss.kind, MT_LOAD);
    issue(MT_LOAD, SZ_QUAD, 44'h48, 1'b0, 1'b0);
    check(got_miss.valid, 1'b0);
    repeat (3) pulse(4'h2);
    pulse(4'h8);
    wait_wr(16'h0005, IOA);
    wait_wr(16'h0030, IOA);
  endtask

  task automatic t_io_load;
    int n;
    n = 0;
    issue(MT_LOAD, SZ_QUAD, IOB, 1'b0, 1'b0);
    issue(MT_LOAD, SZ_QUAD, IOB + 44'h10, 1'b0, 1'b0);
    check(got_miss.valid, 1'b0);
    repeat (30) @(negedge ref_clk_i);
    check(io_rd.valid, 1'b0);
    pulse(4'h1);
    pulse(4'h1);
    while (io_rd.valid !== 1'b1 && n < 100) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(io_rd.mask, 16'h0033);
    check(io_rd.blk, IOB[43:6]);
  endtask

  task automatic t_cfg32;
    @(negedge ref_clk_i);
    srst_i = 1'b1;
    cfg32 = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
    issue(MT_STORE, SZ_QUAD, IOA, 1'b0, 1'b0);
    issue(MT_STORE, SZ_QUAD, IOA + 44'h20, 1'b0, 1'b0);
    issue(MT_STORE, SZ_BW, IOA + 44'h28, 1'b0, 1'b0);
    issue(MT_STORE, SZ_BW, IOA + 44'h30, 1'b0, 1'b0);
    repeat (2) pulse(4'h2);
    wait_wr(16'h0003, IOA);
    pulse(4'h2);
    wait_wr(16'h0300, IOA);
    pulse(4'h2);
    wait_wr(16'h0400, IOA);
    pulse(4'h4);
    wait_wr(16'h1000, IOA);
    issue(MT_STORE, SZ_QUAD, 44'h200, 1'b0, 1'b0);
    check(got_miss.kind, MT_STORE);
    issue(MT_LOAD, SZ_QUAD, 44'h208, 1'b0, 1'b0);
    check(got_miss.valid, 1'b0);
    issue(MT_HINT, SZ_QUAD, 44'h200, 1'b0, 1'b0);
    check(got_miss.kind, MT_HINT);
  endtask

  initial begin
    srst_i = 1'b1;
    req = '0;
    cache_hit = 1'b0;
    cache_dirty = 1'b0;
    pul = 4'h0;
    own_v = 1'b0;
    own_blk = 38'h4;
    cfg32 = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
    check(sys_wr.valid, 1'b0);
    check(req_ready, 1'b1);
    t_mem_store();
    t_io_store();
    t_io_load();
    t_cfg32();
    finish_test;
  end
endmodule // testbench
